// >>> core/monitor_bank_pkg.sv
// constants, types and register map of the motion status monitor bank
package monitor_bank_pkg;
    // -----------------------------------------------------------
    // widths
    // -----------------------------------------------------------
    localparam int AXES = 32;
    localparam int LEDS = 8;
    localparam int IRQ_W = 4;
    // -----------------------------------------------------------
    // register word indexes
    // -----------------------------------------------------------
    localparam logic [3:0] REG_AMP_LO = 4'h0;
    localparam logic [3:0] REG_AMP_HI = 4'h1;
    localparam logic [3:0] REG_MODE_CODE = 4'h2;
    localparam logic [3:0] REG_MODE_LO = 4'h3;
    localparam logic [3:0] REG_MODE_HI = 4'h4;
    localparam logic [3:0] REG_LINK_ERR = 4'h5;
    localparam logic [3:0] REG_CYCLE = 4'h6;
    localparam logic [3:0] REG_LED = 4'h7;
    localparam logic [3:0] REG_IRQ_STAT = 4'h8;
    localparam logic [3:0] REG_IRQ_MASK = 4'h9;
    // -----------------------------------------------------------
    // host link error codes
    // -----------------------------------------------------------
    localparam logic [15:0] LINK_NO_ERR = 16'h0000;
    localparam logic [2:0] LINK_CODE_MAX = 3'h5;
    // -----------------------------------------------------------
    // operation cycles, named in microseconds, held in nanoseconds
    // -----------------------------------------------------------
    localparam logic [15:0] CYC_0P44 = 16'h01B8;
    localparam logic [15:0] CYC_0P8 = 16'h0320;
    localparam logic [15:0] CYC_1P7 = 16'h06A4;
    localparam logic [15:0] CYC_3P5 = 16'h0DAC;
    localparam logic [15:0] CYC_7P1 = 16'h1BBC;
    localparam logic [15:0] CYC_14P2 = 16'h3778;
    localparam logic [5:0] AUTO_AX_FAST = 6'h08;
    localparam logic [5:0] AUTO_AX_MID = 6'h10;
    localparam logic [5:0] LINE_AMP_LIMIT = 6'h09;
    // -----------------------------------------------------------
    // led codes and interrupt bits
    // -----------------------------------------------------------
    localparam logic [1:0] LED_OFF = 2'h0;
    localparam logic [1:0] LED_ON = 2'h1;
    localparam logic [1:0] LED_FLICKER = 2'h2;
    localparam int IRQ_INSTALL = 0;
    localparam int IRQ_MODE = 1;
    localparam int IRQ_LINK = 2;
    localparam int IRQ_RESUME = 3;
    // -----------------------------------------------------------
    // types
    // -----------------------------------------------------------
    typedef enum logic [2:0] {
        CSEL_AUTO = 3'b000,
        CSEL_0P44 = 3'b001,
        CSEL_0P8 = 3'b010,
        CSEL_1P7 = 3'b011,
        CSEL_3P5 = 3'b100,
        CSEL_7P1 = 3'b101,
        CSEL_14P2 = 3'b110
    } cycle_sel_t;
    typedef struct packed {
        logic [15:0] code;
        logic [AXES-1:0] axes;
    } mode_err_t;
    typedef struct packed {
        logic [AXES-1:0] amp;
        mode_err_t mode;
        logic [15:0] link;
        logic [15:0] cyc;
        logic [15:0] led;
        logic [IRQ_W-1:0] stat;
        logic [IRQ_W-1:0] mask;
        logic [15:0] rdata;
        logic irq;
    } state_t;
endpackage : monitor_bank_pkg

// >>> core/motion_cpu_status_monitor_bank.sv
// read-only status monitor bank of the motion cpu
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module motion_cpu_status_monitor_bank (
    input wire logic clk, // 200 MHz system clock
    input wire logic rst_n, // async cpu reset
    input wire logic [3:0] bus_addr, // register word index
    input wire logic [15:0] bus_wdata, // write data
    input wire logic bus_wr, // write strobe
    input wire logic bus_rd, // read strobe
    output logic [15:0] bus_rdata, // read data, cycle after strobe
    input wire logic [31:0] axis_used, // axis configured as used
    input wire logic [5:0] axes_supported, // axes of variant
    input wire logic [31:0] amp_comm_ok, // amplifier link normal
    input wire logic mode_err_valid, // mode error event
    input wire monitor_bank_pkg::mode_err_t mode_err, // its info
    input wire logic link_err_valid, // host link error event
    input wire logic [2:0] link_err_code, // 1..5
    input wire logic link_resumed, // host link normal again
    input wire monitor_bank_pkg::cycle_sel_t cycle_sel, // setting
    input wire logic [5:0] line_amps_max, // most amps on a line
    input wire logic [7:0] led_on, // led lit steadily
    input wire logic [7:0] led_flicker, // led flickering
    output logic irq // level, unmasked status set
);

    // -----------------------------------------------------------
    // helpers
    // -----------------------------------------------------------

    // axes allowed by the controller variant
    function automatic logic [31:0] axis_mask(input logic [5:0] n);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < monitor_bank_pkg::AXES; i++)
        begin
            m[i] = (6'(i) < n);
        end
        return m;
    endfunction : axis_mask

    // number of used axes, picks the automatic cycle
    function automatic logic [5:0] count_axes(input logic [31:0] v);
        logic [5:0] c;
        c = 6'h00;
        for (int i = 0; i < monitor_bank_pkg::AXES; i++)
        begin
            c = c + 6'(v[i]);
        end
        return c;
    endfunction : count_axes

    // two-bit led code, flicker beats steady on
    function automatic logic [1:0] led_code(input logic on,
                                            input logic fl);
        logic [1:0] c;
        c = monitor_bank_pkg::LED_OFF;
        if (fl)
        begin
            c = monitor_bank_pkg::LED_FLICKER;
        end
        else if (on)
        begin
            c = monitor_bank_pkg::LED_ON;
        end
        return c;
    endfunction : led_code

    // -----------------------------------------------------------
    // state
    // -----------------------------------------------------------
    monitor_bank_pkg::state_t st_r;
    monitor_bank_pkg::state_t st_nxt;
    logic [31:0] used_mask;
    logic [15:0] cyc_sel_us;
    logic [5:0] used_cnt;
    logic [monitor_bank_pkg::IRQ_W-1:0] ev;
    logic [monitor_bank_pkg::IRQ_W-1:0] w1c;

    // -----------------------------------------------------------
    // next state
    // -----------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        used_mask = axis_used & axis_mask(axes_supported);
        used_cnt = count_axes(used_mask);
        ev = '0;
        w1c = '0;

        // presence tracked every cycle, so the first edge after
        // reset release is the power-up scan
        st_nxt.amp = amp_comm_ok & used_mask;
        ev[monitor_bank_pkg::IRQ_INSTALL] = (st_nxt.amp != st_r.amp);

        // latest mode error overwrites the previous one
        if (mode_err_valid)
        begin
            st_nxt.mode.code = mode_err.code;
            st_nxt.mode.axes = mode_err.axes
                               & axis_mask(axes_supported);
            ev[monitor_bank_pkg::IRQ_MODE] = 1'b1;
        end

        // an error in the recovery cycle is kept, not wiped
        if (link_err_valid && link_err_code != 3'h0
            && link_err_code <= monitor_bank_pkg::LINK_CODE_MAX)
        begin
            st_nxt.link = {13'h0000, link_err_code};
            ev[monitor_bank_pkg::IRQ_LINK] = 1'b1;
        end
        else if (link_resumed)
        begin
            st_nxt.link = monitor_bank_pkg::LINK_NO_ERR;
            ev[monitor_bank_pkg::IRQ_RESUME] =
                (st_r.link != monitor_bank_pkg::LINK_NO_ERR);
        end

        // selected cycle; automatic follows the axis count
        case (cycle_sel)
            monitor_bank_pkg::CSEL_AUTO:
            begin
                if (used_cnt <= monitor_bank_pkg::AUTO_AX_FAST)
                begin
                    cyc_sel_us = monitor_bank_pkg::CYC_0P44;
                end
                else if (used_cnt <= monitor_bank_pkg::AUTO_AX_MID)
                begin
                    cyc_sel_us = monitor_bank_pkg::CYC_0P8;
                end
                else
                begin
                    cyc_sel_us = monitor_bank_pkg::CYC_1P7;
                end
            end
            monitor_bank_pkg::CSEL_0P44:
                cyc_sel_us = monitor_bank_pkg::CYC_0P44;
            monitor_bank_pkg::CSEL_0P8:
                cyc_sel_us = monitor_bank_pkg::CYC_0P8;
            monitor_bank_pkg::CSEL_1P7:
                cyc_sel_us = monitor_bank_pkg::CYC_1P7;
            monitor_bank_pkg::CSEL_3P5:
                cyc_sel_us = monitor_bank_pkg::CYC_3P5;
            monitor_bank_pkg::CSEL_7P1:
                cyc_sel_us = monitor_bank_pkg::CYC_7P1;
            monitor_bank_pkg::CSEL_14P2:
                cyc_sel_us = monitor_bank_pkg::CYC_14P2;
            default:
                cyc_sel_us = monitor_bank_pkg::CYC_0P8;
        endcase
        // a crowded line cannot keep up with the fastest cycle
        if (cyc_sel_us == monitor_bank_pkg::CYC_0P44
            && line_amps_max >= monitor_bank_pkg::LINE_AMP_LIMIT)
        begin
            cyc_sel_us = monitor_bank_pkg::CYC_0P8;
        end
        st_nxt.cyc = cyc_sel_us;

        // led word, two bits per led
        for (int i = 0; i < monitor_bank_pkg::LEDS; i++)
        begin
            st_nxt.led[2*i +: 2] = led_code(led_on[i],
                                            led_flicker[i]);
        end

        // only the interrupt words take writes; monitor words
        // fall through untouched
        if (bus_wr)
        begin
            case (bus_addr)
                monitor_bank_pkg::REG_IRQ_STAT:
                    w1c = bus_wdata[monitor_bank_pkg::IRQ_W-1:0];
                monitor_bank_pkg::REG_IRQ_MASK:
                    st_nxt.mask = bus_wdata[monitor_bank_pkg::IRQ_W-1:0];
                default:
                    w1c = '0;
            endcase
        end

        // set beats clear so no event is lost
        st_nxt.stat = (st_r.stat & ~w1c) | ev;
        st_nxt.irq = |(st_nxt.stat & st_nxt.mask);

        // read data valid the cycle after the strobe only
        st_nxt.rdata = 16'h0000;
        if (bus_rd)
        begin
            case (bus_addr)
                monitor_bank_pkg::REG_AMP_LO:
                    st_nxt.rdata = st_r.amp[15:0];
                monitor_bank_pkg::REG_AMP_HI:
                    st_nxt.rdata = st_r.amp[31:16];
                monitor_bank_pkg::REG_MODE_CODE:
                    st_nxt.rdata = st_r.mode.code;
                monitor_bank_pkg::REG_MODE_LO:
                    st_nxt.rdata = st_r.mode.axes[15:0];
                monitor_bank_pkg::REG_MODE_HI:
                    st_nxt.rdata = st_r.mode.axes[31:16];
                monitor_bank_pkg::REG_LINK_ERR:
                    st_nxt.rdata = st_r.link;
                monitor_bank_pkg::REG_CYCLE:
                    st_nxt.rdata = st_r.cyc;
                monitor_bank_pkg::REG_LED:
                    st_nxt.rdata = st_r.led;
                monitor_bank_pkg::REG_IRQ_STAT:
                    st_nxt.rdata = {12'h000, st_r.stat};
                monitor_bank_pkg::REG_IRQ_MASK:
                    st_nxt.rdata = {12'h000, st_r.mask};
                default:
                    st_nxt.rdata = 16'h0000;
            endcase
        end
    end

    // -----------------------------------------------------------
    // registers
    // -----------------------------------------------------------

    // reset clears presence; the scan lands one edge after release
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state flops
    assign bus_rdata = st_r.rdata;
    assign irq = st_r.irq;

    // -----------------------------------------------------------
    // assertions
    // -----------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_read_cycle;
        bus_rd && bus_addr == monitor_bank_pkg::REG_CYCLE;
    endsequence

    sequence s_crowded_fast;
        cycle_sel == monitor_bank_pkg::CSEL_0P44
        && line_amps_max >= monitor_bank_pkg::LINE_AMP_LIMIT;
    endsequence

    a_presence_follows: assert property (
        1 |=> st_r.amp == ($past(axis_used) & $past(amp_comm_ok)
                          & axis_mask($past(axes_supported))))
        else $error("presence bitmap does not follow links");

    a_comm_loss_clear: assert property (
        1 |=> (st_r.amp & ~$past(amp_comm_ok)) == 32'h0000_0000)
        else $error("presence kept for silent amplifier");

    a_variant_zero: assert property (
        1 |=> (st_r.amp & ~axis_mask($past(axes_supported)))
              == 32'h0000_0000)
        else $error("presence beyond variant axes");

    a_mode_err_store: assert property (
        mode_err_valid |=> st_r.mode.code == $past(mode_err.code))
        else $error("mode error code not stored");

    a_link_err_store: assert property (
        link_err_valid && link_err_code != 3'h0
        && link_err_code <= monitor_bank_pkg::LINK_CODE_MAX
        |=> st_r.link == {13'h0000, $past(link_err_code)})
        else $error("link error code not stored");

    a_link_resume: assert property (
        link_resumed && !link_err_valid
        |=> st_r.link == monitor_bank_pkg::LINK_NO_ERR)
        else $error("link error word not cleared on recovery");

    a_crowded_line: assert property (
        s_crowded_fast ##1 s_crowded_fast
        |-> st_r.cyc == monitor_bank_pkg::CYC_0P8)
        else $error("fast cycle kept on crowded line");

    a_fixed_cycle: assert property (
        cycle_sel == monitor_bank_pkg::CSEL_3P5
        |=> st_r.cyc == monitor_bank_pkg::CYC_3P5)
        else $error("selected cycle not reported");

    a_cycle_read: assert property (
        s_read_cycle |=> bus_rdata == $past(st_r.cyc))
        else $error("cycle word read wrong");

    a_led_flicker: assert property (
        led_flicker[0] |=> st_r.led[1:0] == monitor_bank_pkg::LED_FLICKER)
        else $error("flicker code wrong");

    a_write_ignored: assert property (
        bus_wr && bus_addr == monitor_bank_pkg::REG_MODE_CODE
        && !mode_err_valid |=> $stable(st_r.mode.code))
        else $error("monitor word changed by write");

    a_irq_level: assert property (
        |(st_r.stat & st_r.mask) && !bus_wr |=> irq)
        else $error("interrupt not raised");

    a_rdata_idle: assert property (
        !bus_rd |=> bus_rdata == 16'h0000)
        else $error("read data left standing");

    a_mode_axes_store: assert property (
        mode_err_valid |=> st_r.mode.axes == ($past(mode_err.axes)
                          & axis_mask($past(axes_supported))))
        else $error("mode error axes not stored");

    a_unused_zero: assert property (
        1 |=> (st_r.amp & ~$past(axis_used)) == 32'h0000_0000)
        else $error("presence set on unused axis");

    a_install_flag: assert property (
        st_r.amp != $past(st_r.amp)
        |-> st_r.stat[monitor_bank_pkg::IRQ_INSTALL])
        else $error("presence change not flagged");

    a_mode_flag: assert property (
        mode_err_valid |=> st_r.stat[monitor_bank_pkg::IRQ_MODE])
        else $error("mode error not flagged");

    a_link_flag: assert property (
        link_err_valid && link_err_code != 3'h0
        && link_err_code <= monitor_bank_pkg::LINK_CODE_MAX
        |=> st_r.stat[monitor_bank_pkg::IRQ_LINK])
        else $error("link error not flagged");

    a_bad_code_kept: assert property (
        link_err_valid && !link_resumed
        && (link_err_code == 3'h0
            || link_err_code > monitor_bank_pkg::LINK_CODE_MAX)
        |=> $stable(st_r.link))
        else $error("invalid link code stored");

    a_resume_flag: assert property (
        link_resumed && !link_err_valid
        && st_r.link != monitor_bank_pkg::LINK_NO_ERR
        |=> st_r.stat[monitor_bank_pkg::IRQ_RESUME])
        else $error("link recovery not flagged");

    a_auto_slow: assert property (
        cycle_sel == monitor_bank_pkg::CSEL_AUTO
        && count_axes(axis_used & axis_mask(axes_supported))
           > monitor_bank_pkg::AUTO_AX_MID
        |=> st_r.cyc == monitor_bank_pkg::CYC_1P7)
        else $error("automatic cycle ignores axis count");

    a_slow_select: assert property (
        cycle_sel == monitor_bank_pkg::CSEL_14P2
        |=> st_r.cyc == monitor_bank_pkg::CYC_14P2)
        else $error("slowest cycle not reported");

    a_led_steady: assert property (
        led_on[1] && !led_flicker[1]
        |=> st_r.led[3:2] == monitor_bank_pkg::LED_ON)
        else $error("steady led code wrong");

    a_led_dark: assert property (
        !led_on[7] && !led_flicker[7]
        |=> st_r.led[15:14] == monitor_bank_pkg::LED_OFF)
        else $error("dark led code wrong");

    a_w1c_clear: assert property (
        bus_wr && bus_addr == monitor_bank_pkg::REG_IRQ_STAT
        && bus_wdata[monitor_bank_pkg::IRQ_MODE] && !mode_err_valid
        |=> !st_r.stat[monitor_bank_pkg::IRQ_MODE])
        else $error("status bit not cleared by write");

endmodule : motion_cpu_status_monitor_bank

// >>> verification/amp_network_model.sv
// servo network stand-in: amplifiers whose link state the bank watches
`timescale 1ns/1ps
module amp_network_model (
    input wire logic clk, // system clock
    input wire logic rst_n, // cpu reset
    input wire logic [31:0] fitted, // amp installed per axis
    input wire logic [31:0] powered, // amp powered per axis
    input wire logic [31:0] cable_ok, // cable intact per axis
    output logic [31:0] comm_ok, // link normal per axis
    output logic [5:0] line_amps_max // most live amps on one line
);
    logic [31:0] up;
    logic [5:0] n_lo;
    logic [5:0] n_hi;
    // an amp answers only when fitted, powered and cabled
    assign up = fitted & powered & cable_ok;
    // axes 1-16 on line one, 17-32 on line two
    always_comb
    begin
        n_lo = 6'h00;
        n_hi = 6'h00;
        for (int i = 0; i < 16; i++)
        begin
            n_lo = n_lo + 6'(up[i]);
            n_hi = n_hi + 6'(up[i+16]);
        end
    end
    // link loss is seen one poll late, never at once
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            comm_ok <= '0;
            line_amps_max <= 6'h00;
        end
        else
        begin
            comm_ok <= up;
            line_amps_max <= (n_lo > n_hi) ? n_lo : n_hi;
        end
    end
endmodule : amp_network_model

// >>> verification/tb_motion_cpu_status_monitor_bank.sv
// self-checking bench for the status monitor bank
`timescale 1ns/1ps
module tb_motion_cpu_status_monitor_bank;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] bus_addr = 4'h0;
    logic [15:0] bus_wdata = 16'h0000;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [15:0] bus_rdata;
    logic [31:0] axis_used = 32'h0000_0010;
    logic [5:0] axes_supported = 6'h18;
    logic [31:0] amp_comm_ok;
    logic mode_err_valid = 1'b0;
    monitor_bank_pkg::mode_err_t mode_err = '0;
    logic link_err_valid = 1'b0;
    logic [2:0] link_err_code = 3'h0;
    logic link_resumed = 1'b0;
    monitor_bank_pkg::cycle_sel_t cycle_sel = monitor_bank_pkg::CSEL_AUTO;
    logic [5:0] line_amps_max;
    logic [7:0] led_on = 8'h00;
    logic [7:0] led_flicker = 8'h00;
    logic irq;
    logic [31:0] fitted = 32'hffff_ffff;
    logic [31:0] powered = 32'hffff_ffff;
    logic [31:0] cable_ok = 32'hffff_ffff;
    logic [31:0] lfsr = 32'hdd07_7c65;
    logic [15:0] rd_val;
    logic [15:0] snap [8];
    int n_errors = 0;
    int checks_done = 0;

    always #2.5 clk = ~clk;

    motion_cpu_status_monitor_bank dut (.clk, .rst_n, .bus_addr, .bus_wdata,
        .bus_wr, .bus_rd, .bus_rdata, .axis_used, .axes_supported,
        .amp_comm_ok, .mode_err_valid, .mode_err, .link_err_valid,
        .link_err_code, .link_resumed, .cycle_sel, .line_amps_max, .led_on,
        .led_flicker, .irq);
    amp_network_model far (.clk, .rst_n, .fitted, .powered, .cable_ok,
        .comm_ok(amp_comm_ok), .line_amps_max);

    // ------------------------------------------------------------
    // expectation helpers and bus tasks
    // ------------------------------------------------------------
    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : nxt
    function automatic logic [31:0] vmask(input logic [5:0] n);
        return (n >= 6'h20) ? 32'hffff_ffff : (32'h0000_0001 << n) - 1;
    endfunction : vmask
    // presence as software should see it after masking
    function automatic logic [31:0] exp_amp();
        return axis_used & fitted & powered & cable_ok
               & vmask(axes_supported);
    endfunction : exp_amp
    function automatic logic [15:0] exp_cyc();
        logic [15:0] v;
        logic [31:0] up;
        int n;
        n = $countones(axis_used & vmask(axes_supported));
        up = fitted & powered & cable_ok;
        case (cycle_sel)
            monitor_bank_pkg::CSEL_AUTO: v = (n <= 8) ?
                monitor_bank_pkg::CYC_0P44 : (n <= 16) ?
                monitor_bank_pkg::CYC_0P8 : monitor_bank_pkg::CYC_1P7;
            monitor_bank_pkg::CSEL_0P44: v = monitor_bank_pkg::CYC_0P44;
            monitor_bank_pkg::CSEL_1P7: v = monitor_bank_pkg::CYC_1P7;
            monitor_bank_pkg::CSEL_3P5: v = monitor_bank_pkg::CYC_3P5;
            monitor_bank_pkg::CSEL_7P1: v = monitor_bank_pkg::CYC_7P1;
            monitor_bank_pkg::CSEL_14P2: v = monitor_bank_pkg::CYC_14P2;
            default: v = monitor_bank_pkg::CYC_0P8;
        endcase
        // crowded line cannot run the fastest cycle
        if (($countones(up[15:0]) >= 9 || $countones(up[31:16]) >= 9)
            && v == monitor_bank_pkg::CYC_0P44)
            v = monitor_bank_pkg::CYC_0P8;
        return v;
    endfunction : exp_cyc
    function automatic logic [15:0] exp_led();
        logic [15:0] v;
        for (int i = 0; i < 8; i++)
            v[2*i+:2] = led_flicker[i] ? 2'h2 : (led_on[i] ? 2'h1 : 2'h0);
        return v;
    endfunction : exp_led
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: saw %h, expected %h", $time,
                     seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd <= 1'b0;
        @(posedge clk);
        rd_val = bus_rdata;
    endtask : rd
    task automatic rchk(input logic [3:0] a, input logic [15:0] e);
        rd(a);
        chk(rd_val, e);
    endtask : rchk
    task automatic link_ev(input logic err, input logic [2:0] c);
        @(posedge clk);
        link_err_valid <= err;
        link_resumed <= !err;
        link_err_code <= c;
        @(posedge clk);
        link_err_valid <= 1'b0;
        link_resumed <= 1'b0;
    endtask : link_ev
    task automatic close_out();
        $display("checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        monitor_bank_pkg::mode_err_t me;
        tick(5);
        rst_n <= 1'b1;
        tick(3);
        rchk(monitor_bank_pkg::REG_AMP_LO, 16'(exp_amp()));
        rchk(monitor_bank_pkg::REG_AMP_HI, 16'(exp_amp() >> 16));
        $display("power-up scan test finished");
        // a lost cable and a powered-off amp both count as absent
        wr(monitor_bank_pkg::REG_IRQ_STAT, 16'h000f);
        cable_ok[4] <= 1'b0;
        tick(3);
        rchk(monitor_bank_pkg::REG_AMP_LO, 16'h0000);
        rd(monitor_bank_pkg::REG_IRQ_STAT);
        chk(rd_val & 16'h0001, 16'h0001);
        cable_ok[4] <= 1'b1;
        tick(3);
        rchk(monitor_bank_pkg::REG_AMP_LO, 16'h0010);
        powered[4] <= 1'b0;
        tick(3);
        rchk(monitor_bank_pkg::REG_AMP_LO, 16'h0000);
        $display("presence tracking test finished");
        // sweep every selection, sparse lines first, then line one full
        for (int i = 0; i < 16; i++)
        begin
            lfsr = nxt(lfsr);
            axis_used <= lfsr;
            axes_supported <= 6'(lfsr[31:27] + lfsr[0]);
            lfsr = nxt(lfsr);
            fitted <= (i < 8) ? lfsr & 32'h00ff_00ff : 32'hffff_ffff;
            powered <= (i < 8) ? 32'hffff_ffff : lfsr | 32'h0000_ffff;
            cycle_sel <= monitor_bank_pkg::cycle_sel_t'(i[2:0]);
            led_on <= lfsr[7:0];
            led_flicker <= lfsr[15:8];
            tick(3);
            rchk(monitor_bank_pkg::REG_AMP_LO, 16'(exp_amp()));
            rchk(monitor_bank_pkg::REG_AMP_HI, 16'(exp_amp() >> 16));
            rchk(monitor_bank_pkg::REG_CYCLE, exp_cyc());
            rchk(monitor_bank_pkg::REG_LED, exp_led());
        end
        $display("cycle, led and random presence test finished");
        // two events back to back: the later one must stick
        for (int k = 0; k < 2; k++)
        begin
            lfsr = nxt(lfsr);
            me = {lfsr[15:0], nxt(lfsr)};
            @(posedge clk);
            mode_err_valid <= 1'b1;
            mode_err <= me;
        end
        @(posedge clk);
        mode_err_valid <= 1'b0;
        tick(1);
        rchk(monitor_bank_pkg::REG_MODE_CODE, me.code);
        me.axes = me.axes & vmask(axes_supported);
        rchk(monitor_bank_pkg::REG_MODE_LO, me.axes[15:0]);
        rchk(monitor_bank_pkg::REG_MODE_HI, me.axes[31:16]);
        $display("mode error test finished");
        // every link code, each followed by recovery; irq on link bit
        wr(monitor_bank_pkg::REG_IRQ_MASK, 16'h0004);
        for (int c = 1; c <= 5; c++)
        begin
            wr(monitor_bank_pkg::REG_IRQ_STAT, 16'h000f);
            link_ev(1'b1, 3'(c));
            tick(2);
            chk({15'h0000, irq}, 16'h0001);
            rchk(monitor_bank_pkg::REG_LINK_ERR, 16'(c));
            link_ev(1'b0, 3'h0);
            rchk(monitor_bank_pkg::REG_LINK_ERR, 16'h0000);
        end
        wr(monitor_bank_pkg::REG_IRQ_STAT, 16'h0004);
        tick(2);
        chk({15'h0000, irq}, 16'h0000);
        link_ev(1'b1, 3'h6);
        rchk(monitor_bank_pkg::REG_LINK_ERR, 16'h0000);
        $display("host link and interrupt test finished");
        // monitor words must shrug off writes
        snap = '{16'(exp_amp()), 16'(exp_amp() >> 16), me.code,
                 me.axes[15:0], me.axes[31:16], 16'h0000, exp_cyc(),
                 exp_led()};
        for (int a = 0; a < 8; a++)
            wr(4'(a), ~snap[a]);
        for (int a = 0; a < 8; a++)
            rchk(4'(a), snap[a]);
        rchk(4'hc, 16'h0000);
        $display("read-only test finished");
        close_out();
    end

    // hang guard
    initial
    begin
        tick(60000);
        n_errors++;
        close_out();
    end
endmodule : tb_motion_cpu_status_monitor_bank
